// file: shared/mspi_pkg.sv
package mspi_pkg;
	// --------------------------------------------------------------
	// bus map (byte addresses, one word each)
	// --------------------------------------------------------------
	localparam int          ADDR_W    = 5;
	localparam int          DATA_W    = 32;
	localparam logic [4:0]  OFS_CTRL  = 5'h00;
	localparam logic [4:0]  OFS_EVCR  = 5'h04;
	localparam logic [4:0]  OFS_NVCR  = 5'h08;
	localparam logic [4:0]  OFS_STAT  = 5'h0C;
	localparam logic [4:0]  OFS_RXD   = 5'h10;
	localparam logic [4:0]  OFS_TXD   = 5'h14;

	// --------------------------------------------------------------
	// control fields
	// --------------------------------------------------------------
	localparam int          CTL_OUTEN = 0;
	localparam int          CTL_XW_LO = 1;
	localparam int          CTL_PE    = 3;
	localparam int          CTL_RESC  = 4;
	localparam int          CTL_BOOT  = 5;
	localparam logic [3:0]  CTL_RST   = 4'h0;

	// --------------------------------------------------------------
	// configuration fields and reset values
	// --------------------------------------------------------------
	localparam int          EV_DUALN  = 6;
	localparam int          EV_QUADN  = 7;
	localparam int          NV_DUALN  = 2;
	localparam int          NV_QUADN  = 3;
	localparam logic [7:0]  EVCR_RST  = 8'hFF;
	localparam logic [15:0] NVCR_RST  = 16'hFFFF;

	// --------------------------------------------------------------
	// status and receive data fields
	// --------------------------------------------------------------
	localparam int          ST_OVR    = 7;
	localparam int          RX_CMD    = 8;
	localparam int          RX_VLD    = 9;

	// --------------------------------------------------------------
	// link constants
	// --------------------------------------------------------------
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [3:0]  LANES_OFF = 4'hF;
	localparam int          FIFO_DEP  = 4;

	typedef enum logic [1:0] {
		MSPI_EXT,
		MSPI_DUAL,
		MSPI_QUAD
	} mspi_proto_e;
endpackage

// file: src/mspi_core.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// ------------------------------------------------------------------
// receive byte buffer
// ------------------------------------------------------------------
module mspi_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [PW:0]      cnt_ff, nxt_cnt;
	logic             push, pop;

	// pointers wrap by index; count gives honest full and empty
	always_comb begin
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		nxt_wr  = push ? PW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
		nxt_rd  = pop ? PW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
		nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage has no reset; empty flag guards reads
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	assign in_ready  = (cnt_ff != FULL);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
endmodule // mspi_fifo

// ------------------------------------------------------------------
// serial front end with protocol selection
// ------------------------------------------------------------------
module mspi_core #(
	parameter int FIFO_DEPTH = mspi_pkg::FIFO_DEP
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire logic [mspi_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [mspi_pkg::DATA_W-1:0] avs_writedata,
	output logic      [mspi_pkg::DATA_W-1:0] avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        spi_sclk,
	input  wire logic                        spi_cs_n,
	input  wire logic                  [3:0] io_in,
	output logic                       [3:0] io_out,
	output logic                       [3:0] io_oe_n,
	input  wire logic                        hv_supply
);
	import mspi_pkg::*;

	// lanes used by a transfer; command phase of extended is one lane
	function automatic logic [3:0] lanes(mspi_proto_e p, logic cmd,
		logic [1:0] xw);
		case (p)
			MSPI_DUAL: lanes = 4'h2;
			MSPI_QUAD: lanes = 4'h4;
			default:   lanes = cmd ? 4'h1 :
				(xw == 2'h2 ? 4'h4 : (xw == 2'h1 ? 4'h2 : 4'h1));
		endcase
	endfunction

	// protocol from configuration bits; quad beats dual
	function automatic mspi_proto_e pick(logic quad_n, logic dual_n);
		if (!quad_n) begin
			pick = MSPI_QUAD;
		end else if (!dual_n) begin
			pick = MSPI_DUAL;
		end else begin
			pick = MSPI_EXT;
		end
	endfunction

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic [6:0] s1_ff, s2_ff;
	logic       sclk_d_ff, cs_d_ff;
	logic       sclk_s, cs_s, hv_s;
	logic [3:0] io_s;

	// first stage is read by the second stage only
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s1_ff     <= 7'h01;
			s2_ff     <= 7'h01;
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b1;
		end else begin
			s1_ff     <= {io_in, hv_supply, spi_sclk, spi_cs_n};
			s2_ff     <= s1_ff;
			sclk_d_ff <= sclk_s;
			cs_d_ff   <= cs_s;
		end
	end

	assign cs_s   = s2_ff[0];
	assign sclk_s = s2_ff[1];
	assign hv_s   = s2_ff[2];
	assign io_s   = s2_ff[6:3];

	logic sel, rise, fall, cs_fall;
	assign sel     = !cs_s;
	assign rise    = sel && sclk_s && !sclk_d_ff;
	assign fall    = sel && !sclk_s && sclk_d_ff;
	assign cs_fall = !cs_s && cs_d_ff;

	// --------------------------------------------------------------
	// bus slave and configuration
	// --------------------------------------------------------------
	logic [3:0]  ctl_ff, nxt_ctl;
	logic [7:0]  evcr_ff, nxt_evcr;
	logic [15:0] nvcr_ff, nxt_nvcr;
	logic [7:0]  txh_ff, nxt_txh;
	logic        txf_ff, nxt_txf;
	logic        ovr_ff, nxt_ovr;
	logic        wait_ff, nxt_wait;
	logic        cpol_ff;
	logic [31:0] rd_ff, nxt_rd;
	mspi_proto_e psel_ff, nxt_psel, peff;
	logic        acc, wr, rescue, reboot, rx_pop, tx_take, ovr_set;
	logic [8:0]  rx_q;
	logic        rx_qv;

	// reads are captured as waitrequest drops; a write lands only at the
	// edge where the master sees waitrequest low, as the bus defines it
	always_comb begin
		acc      = (avs_read || avs_write) && wait_ff;
		wr       = avs_write && !wait_ff;
		nxt_wait = !acc;
		rx_pop   = acc && avs_read && avs_address == OFS_RXD;
		rescue   = wr && avs_address == OFS_CTRL &&
			avs_writedata[CTL_RESC];
		reboot   = wr && avs_address == OFS_CTRL &&
			avs_writedata[CTL_BOOT];
		nxt_ctl  = ctl_ff;
		nxt_evcr = evcr_ff;
		nxt_nvcr = nvcr_ff;
		nxt_txh  = txh_ff;
		nxt_txf  = txf_ff && !tx_take;
		nxt_ovr  = ovr_ff;
		nxt_psel = psel_ff;
		nxt_rd   = rd_ff;
		if (wr) begin
			case (avs_address)
				OFS_CTRL: nxt_ctl = avs_writedata[3:0];
				OFS_EVCR: begin
					nxt_evcr = avs_writedata[7:0];
					nxt_psel = pick(avs_writedata[EV_QUADN],
						avs_writedata[EV_DUALN]);
				end
				OFS_NVCR: nxt_nvcr = avs_writedata[15:0];
				OFS_STAT: if (avs_writedata[ST_OVR]) nxt_ovr = 1'b0;
				OFS_TXD: begin
					nxt_txh = avs_writedata[7:0];
					nxt_txf = 1'b1;
				end
				default: ;
			endcase
		end
		if (rescue) begin
			nxt_psel = MSPI_EXT;
		end
		// reboot behaves as a power-on: volatile choice dropped
		if (reboot) begin
			nxt_evcr = EVCR_RST;
			nxt_psel = pick(nvcr_ff[NV_QUADN], nvcr_ff[NV_DUALN]);
		end
		if (ovr_set) begin
			nxt_ovr = 1'b1;
		end
		if (acc && avs_read) begin
			case (avs_address)
				OFS_CTRL: nxt_rd = {28'h0, ctl_ff};
				OFS_EVCR: nxt_rd = {24'h0, evcr_ff};
				OFS_NVCR: nxt_rd = {16'h0, nvcr_ff};
				OFS_STAT: nxt_rd = {22'h0, hv_s, cpol_ff, ovr_ff, !txf_ff,
					rx_qv, sel, psel_ff, peff};
				OFS_RXD:  nxt_rd = {22'h0, rx_qv, rx_q};
				default:  nxt_rd = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ctl_ff  <= CTL_RST;
			evcr_ff <= EVCR_RST;
			nvcr_ff <= NVCR_RST;
			txh_ff  <= 8'h00;
			txf_ff  <= 1'b0;
			ovr_ff  <= 1'b0;
			wait_ff <= 1'b1;
			rd_ff   <= 32'h0;
			psel_ff <= pick(NVCR_RST[NV_QUADN], NVCR_RST[NV_DUALN]);
		end else begin
			ctl_ff  <= nxt_ctl;
			evcr_ff <= nxt_evcr;
			nvcr_ff <= nxt_nvcr;
			txh_ff  <= nxt_txh;
			txf_ff  <= nxt_txf;
			ovr_ff  <= nxt_ovr;
			wait_ff <= nxt_wait;
			rd_ff   <= nxt_rd;
			psel_ff <= nxt_psel;
		end
	end

	assign avs_waitrequest = wait_ff;
	assign avs_readdata    = rd_ff;

	// supply-assisted quad cycle answers in extended until pin drops
	assign peff = (psel_ff == MSPI_QUAD && ctl_ff[CTL_PE] && hv_s) ?
		MSPI_EXT : psel_ff;

	// --------------------------------------------------------------
	// serial link
	// --------------------------------------------------------------
	logic [7:0] rsh_ff, nxt_rsh, tsh_ff, nxt_tsh, src;
	logic [3:0] rcnt_ff, nxt_rcnt, tleft_ff, nxt_tleft, rsum;
	logic [3:0] out_ff, nxt_out, oe_ff, nxt_oe, win, wout;
	logic       cmd_ff, nxt_cmd, pv_ff, nxt_pv, nxt_cpol;
	logic [8:0] pd_ff, nxt_pd;
	logic       pin_rdy, done, outen;

	// input capture is idle while the device talks back
	always_comb begin
		outen     = ctl_ff[CTL_OUTEN];
		win       = lanes(peff, cmd_ff, ctl_ff[2:1]);
		wout      = lanes(peff, 1'b0, ctl_ff[2:1]);
		rsum      = rcnt_ff + win;
		done      = rise && !outen && rsum == BYTE_BITS;
		src       = (tleft_ff == 4'h0) ? txh_ff : tsh_ff;
		tx_take   = fall && outen && tleft_ff == 4'h0;
		nxt_rsh   = rsh_ff;
		nxt_rcnt  = rcnt_ff;
		nxt_cmd   = cmd_ff;
		nxt_tsh   = tsh_ff;
		nxt_tleft = tleft_ff;
		nxt_out   = out_ff;
		nxt_cpol  = cpol_ff;
		nxt_pv    = pv_ff && !pin_rdy;
		nxt_pd    = pd_ff;
		ovr_set   = 1'b0;
		// idle clock level at select tells mode 0 from mode 3; shown in status
		if (cs_fall) begin
			nxt_cpol = sclk_s;
		end
		// capture on rising edge in either mode and any protocol
		if (rise && !outen) begin
			case (win)
				4'h1:    nxt_rsh = {rsh_ff[6:0], io_s[0]};
				4'h2:    nxt_rsh = {rsh_ff[5:0], io_s[1:0]};
				default: nxt_rsh = {rsh_ff[3:0], io_s};
			endcase
			nxt_rcnt = done ? 4'h0 : rsum;
		end
		// a full pending slot with a full buffer loses the new byte
		if (done) begin
			nxt_cmd = 1'b0;
			if (pv_ff && !pin_rdy) begin
				ovr_set = 1'b1;
			end else begin
				nxt_pv = 1'b1;
				nxt_pd = {cmd_ff, nxt_rsh};
			end
		end
		// launch on the falling edge, most significant lanes first
		if (fall && outen) begin
			case (wout)
				4'h1:    nxt_out = {2'b00, src[7], 1'b0};
				4'h2:    nxt_out = {2'b00, src[7:6]};
				default: nxt_out = src[7:4];
			endcase
			nxt_tsh   = 8'(src << wout);
			nxt_tleft = ((tleft_ff == 4'h0) ? BYTE_BITS : tleft_ff) - wout;
		end
		// end of frame drops partial bytes
		if (!sel) begin
			nxt_rcnt  = 4'h0;
			nxt_cmd   = 1'b1;
			nxt_tleft = 4'h0;
		end
		// one lane in single-lane mode, all lanes of the width else
		nxt_oe = LANES_OFF;
		if (sel && outen) begin
			case (wout)
				4'h1:    nxt_oe = 4'hD;
				4'h2:    nxt_oe = 4'hC;
				default: nxt_oe = 4'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rsh_ff   <= 8'h00;
			rcnt_ff  <= 4'h0;
			cmd_ff   <= 1'b1;
			tsh_ff   <= 8'h00;
			tleft_ff <= 4'h0;
			out_ff   <= 4'h0;
			oe_ff    <= LANES_OFF;
			cpol_ff  <= 1'b0;
			pv_ff    <= 1'b0;
			pd_ff    <= 9'h000;
		end else begin
			rsh_ff   <= nxt_rsh;
			rcnt_ff  <= nxt_rcnt;
			cmd_ff   <= nxt_cmd;
			tsh_ff   <= nxt_tsh;
			tleft_ff <= nxt_tleft;
			out_ff   <= nxt_out;
			oe_ff    <= nxt_oe;
			cpol_ff  <= nxt_cpol;
			pv_ff    <= nxt_pv;
			pd_ff    <= nxt_pd;
		end
	end

	assign io_out  = out_ff;
	assign io_oe_n = oe_ff;

	// pending byte stalls until the buffer has room
	mspi_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_rxq (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_data   (pd_ff),
		.in_valid  (pv_ff),
		.in_ready  (pin_rdy),
		.out_data  (rx_q),
		.out_valid (rx_qv),
		.out_ready (rx_pop)
	);

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	rx_on_rise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!$stable(rsh_ff) |-> $past(rise && !outen))
		else $error("input shifted without rising clock");

	tx_on_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!$stable(out_ff) |-> $past(fall))
		else $error("output changed without falling clock");

	deselect_hiz_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!sel |=> oe_ff == LANES_OFF)
		else $error("data lines driven while unselected");

	ext_cmd_lane_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(peff == MSPI_EXT && cmd_ff) |-> win == 4'h1)
		else $error("extended command not on one lane");

	dual_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(wr && avs_address == OFS_EVCR && avs_writedata[7:6] == 2'b10 &&
		!rescue && !reboot) |=> psel_ff == MSPI_DUAL)
		else $error("volatile dual select missed");

	quad_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(wr && avs_address == OFS_EVCR && !avs_writedata[EV_QUADN])
		|=> psel_ff == MSPI_QUAD)
		else $error("volatile quad select missed");

	rescue_ext_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		rescue |=> psel_ff == MSPI_EXT)
		else $error("rescue did not restore extended");

	boot_dual_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(reboot && nvcr_ff[NV_QUADN] && !nvcr_ff[NV_DUALN])
		|=> psel_ff == MSPI_DUAL)
		else $error("boot did not enter dual");

	boot_quad_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(reboot && !nvcr_ff[NV_QUADN]) |=> psel_ff == MSPI_QUAD)
		else $error("boot did not enter quad");

	hv_fallback_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(psel_ff == MSPI_QUAD && ctl_ff[CTL_PE] && hv_s) |-> peff == MSPI_EXT
		&& (!cmd_ff || win == 4'h1))
		else $error("no extended fallback in assisted cycle");

	hv_resume_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(psel_ff == MSPI_QUAD && !hv_s) |-> peff == MSPI_QUAD && win == 4'h4)
		else $error("quad not resumed after supply low");

	bus_answer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		acc |=> !wait_ff ##1 wait_ff)
		else $error("waitrequest answer not one cycle");
endmodule // mspi_core

// file: sim/mspi_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// spi bus master stand-in
// ------------------------------------------------------------------
module mspi_host_model (
	input  wire logic       core_clk,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe_n,
	output logic            spi_sclk,
	output logic            spi_cs_n,
	output logic      [3:0] io_in
);
	logic [3:0] host_drv;
	logic       idle_lvl;

	// wire level: the device owns a lane only while its enable is low
	assign io_in = (io_oe_n & host_drv) | (~io_oe_n & io_out);

	// every line starts at a defined level, never floating
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		host_drv = 4'h0;
		idle_lvl = 1'b0;
	end

	// half a link period: 40 ns gives the 80 ns link clock
	task automatic half();
		repeat (4) @(posedge core_clk);
	endtask

	// park the clock at the mode's idle level before selecting
	task automatic frame_open(input logic cpol);
		spi_sclk <= cpol;
		idle_lvl = cpol;
		half();
		spi_cs_n <= 1'b0;
		half();
	endtask

	// one byte msb first; host data moves with the falling clock so the
	// device can take it on the rising one; the returned byte only reads
	// io_line_1, sampled late in the high phase, so it suits one lane only
	task automatic shift(input int lanes, input logic [7:0] tx, output logic [7:0] rx);
		logic [7:0] sh;
		sh = tx;
		rx = 8'h00;
		for (int s = 0; s < 8 / lanes; s++) begin
			spi_sclk <= 1'b0;
			case (lanes)
				1: host_drv[0] <= sh[7];
				2: host_drv[1:0] <= sh[7:6];
				default: host_drv <= sh[7:4];
			endcase
			sh = sh << lanes;
			half();
			spi_sclk <= 1'b1;
			half();
			rx = {rx[6:0], io_out[1]};
		end
	endtask

	// mode 0 returns the clock low before deselect; released lines flip
	// so a stale value cannot pass for a fresh one
	task automatic frame_close();
		if (!idle_lvl) begin
			spi_sclk <= 1'b0;
			half();
		end
		spi_cs_n <= 1'b1;
		host_drv <= ~host_drv;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // mspi_host_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import mspi_pkg::*;

	logic        core_clk;
	logic        reset_n;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        spi_sclk;
	logic        spi_cs_n;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe_n;
	logic        hv_supply;
	int          failures;
	int          checks_done;

	mspi_core mspi_core_i (.core_clk(core_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .hv_supply(hv_supply));

	mspi_host_model mspi_host_model_i (.core_clk(core_clk), .io_out(io_out),
		.io_oe_n(io_oe_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .io_in(io_in));

	// ------------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------------
	task automatic finish_test();
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon access; request held until waitrequest is sampled low,
	// a slave that never answers is left to the watchdog
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic exp_rd(input string nm, input logic [4:0] a, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(nm, x & m, e);
	endtask

	// one frame: command byte then one data byte, both popped and judged
	task automatic rx_frame(input int cl, input int dl, input logic cpol,
			input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		mspi_host_model_i.frame_open(cpol);
		mspi_host_model_i.shift(cl, c, r);
		mspi_host_model_i.shift(dl, d, r);
		mspi_host_model_i.frame_close();
		exp_rd("rx cmd", OFS_RXD, 32'h3FF, {22'h0, 2'b11, c});
		exp_rd("rx data", OFS_RXD, 32'h3FF, {22'h0, 2'b10, d});
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		exp_rd("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		exp_rd("evcr", OFS_EVCR, 32'hFFFFFFFF, 32'hFF);
		exp_rd("nvcr", OFS_NVCR, 32'hFFFFFFFF, 32'hFFFF);
		exp_rd("proto", OFS_STAT, 32'hF, 32'h0);
		exp_rd("unmapped", 5'h18, 32'hFFFFFFFF, 32'h0);
		check("oe idle", {28'h0, io_oe_n}, 32'hF);
	endtask

	// each protocol in both clock modes; data width 4 applies to extended only
	task automatic proto_rx(input logic [7:0] ev, input logic [1:0] p, input int ln,
			input int dl);
		wr(OFS_EVCR, {24'h0, ev});
		exp_rd("proto", OFS_STAT, 32'hF, {28'h0, p, p});
		for (int m = 0; m < 2; m++) begin
			rx_frame(ln, dl, m[0], 8'hA5 ^ ev, 8'h3C ^ ev);
		end
	endtask

	task automatic t_protocols();
		wr(OFS_CTRL, 32'h4);
		proto_rx(8'hFF, 2'h0, 1, 4);
		wr(OFS_CTRL, 32'h2);
		rx_frame(1, 2, 1'b1, 8'h96, 8'h69);
		wr(OFS_CTRL, 32'h4);
		proto_rx(8'hBF, 2'h1, 2, 2);
		proto_rx(8'h7F, 2'h2, 4, 4);
		proto_rx(8'h3F, 2'h2, 4, 4);
		proto_rx(8'hFF, 2'h0, 1, 4);
	endtask

	// supply-assisted cycle in quad drops to one command lane, then returns
	task automatic t_fallback();
		wr(OFS_EVCR, 32'h7F);
		wr(OFS_CTRL, 32'hC);
		hv_supply <= 1'b1;
		repeat (6) @(posedge core_clk);
		exp_rd("fallback", OFS_STAT, 32'hF, 32'h8);
		rx_frame(1, 4, 1'b0, 8'hA1, 8'h5E);
		hv_supply <= 1'b0;
		repeat (6) @(posedge core_clk);
		exp_rd("resume", OFS_STAT, 32'hF, 32'hA);
		wr(OFS_CTRL, 32'h10);
		exp_rd("rescue", OFS_STAT, 32'hF, 32'h0);
		exp_rd("ctrl self clear", OFS_CTRL, 32'h30, 32'h0);
	endtask

	// reboot stands in for power-on: volatile choice lost, nvcr decides
	task automatic t_boot();
		logic [15:0] nv [4] = '{16'hFFFB, 16'hFFF7, 16'hFFF3, 16'hFFFF};
		logic [3:0]  pe [4] = '{4'h5, 4'hA, 4'hA, 4'h0};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_EVCR, 32'hBF);
			wr(OFS_NVCR, {16'h0, nv[i]});
			wr(OFS_CTRL, 32'h20);
			exp_rd("boot proto", OFS_STAT, 32'hF, {28'h0, pe[i]});
			exp_rd("evcr reload", OFS_EVCR, 32'hFF, 32'hFF);
		end
	endtask

	// transmit in mode 3: bits follow falling edges on io_line_1 only
	task automatic t_transmit();
		logic [7:0] r;
		wr(OFS_TXD, 32'hC3);
		wr(OFS_CTRL, 32'h1);
		mspi_host_model_i.frame_open(1'b1);
		mspi_host_model_i.shift(1, 8'h00, r);
		check("tx byte", {24'h0, r}, 32'hC3);
		check("oe selected", {28'h0, io_oe_n}, 32'hD);
		mspi_host_model_i.frame_close();
		check("oe released", {28'h0, io_oe_n}, 32'hF);
		exp_rd("mode 3 idle", OFS_STAT, 32'h100, 32'h100);
		wr(OFS_CTRL, 32'h0);
	endtask

	// host never reads while six bytes arrive: five fit, sixth overruns
	task automatic t_fill();
		logic [7:0] r;
		mspi_host_model_i.frame_open(1'b0);
		for (int i = 0; i < 6; i++) begin
			mspi_host_model_i.shift(1, 8'h10 + i[7:0], r);
		end
		mspi_host_model_i.frame_close();
		exp_rd("overrun", OFS_STAT, 32'hA0, 32'hA0);
		exp_rd("mode 0 idle", OFS_STAT, 32'h100, 32'h0);
		for (int i = 0; i < 5; i++) begin
			exp_rd("drain", OFS_RXD, 32'h3FF, {22'h0, 1'b1, i == 0, 8'h10 + i[7:0]});
		end
		exp_rd("empty", OFS_RXD, 32'h200, 32'h0);
		wr(OFS_STAT, 32'h80);
		exp_rd("ovr clear", OFS_STAT, 32'hA0, 32'h0);
	endtask

	// ------------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// roughly seventeen hundred cycles of traffic; a hang ends the run
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		finish_test();
	end

	initial begin
		failures = 0;
		checks_done = 0;
		reset_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hv_supply = 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_protocols();
		t_fallback();
		t_boot();
		t_transmit();
		t_fill();
		finish_test();
	end
endmodule // tb_top
